// [rtl/host_fifo_port_access.sv]
`timescale 1ns/1ps
`include "host_fifo_regs.svh"
module host_fifo_port_access
  import host_fifo_pkg::*;
#(
  parameter int DATA_DEPTH = 16,
  parameter int STS_DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic [7:1] host_addr,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  input wire logic rx_data_valid,
  input wire logic [31:0] rx_data,
  output logic rx_data_ready,
  input wire logic rx_sts_valid,
  input wire logic [31:0] rx_sts,
  output logic rx_sts_ready,
  input wire logic tx_sts_valid,
  input wire logic [31:0] tx_sts,
  output logic tx_sts_ready,
  output logic tx_data_valid,
  output logic [31:0] tx_data,
  input wire logic tx_data_ready
);
  // two-flop synchronisers on every host pin
  logic [25:0] pin_meta;
  logic [25:0] pin_sync;
  logic rd_prev;
  logic wr_prev;
  logic [15:0] rd_hi;
  logic [15:0] wr_lo;
  logic [31:0] tx_stage;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_meta <= {3'b111, 23'h000000};
      pin_sync <= {3'b111, 23'h000000};
    end else begin
      pin_meta <= {host_cs_n, host_rd_n, host_wr_n, host_addr, host_data_in};
      pin_sync <= pin_meta;
    end
  end

  wire cs_s = !pin_sync[25];
  wire rd_act = cs_s && !pin_sync[24];
  wire wr_act = cs_s && !pin_sync[23];
  wire [7:0] acc_byte = {pin_sync[22:16], 1'b0};
  wire [7:0] acc_word = {acc_byte[7:2], 2'b00};
  wire [15:0] din_s = pin_sync[15:0];
  wire start_rd = rd_act && !rd_prev;
  wire start_wr = wr_act && !wr_prev;
  wire lo_half = !acc_byte[1];
  wire fetch = start_rd && lo_half;
  wire finish_rd = start_rd && !lo_half;
  wire finish_wr = start_wr && !lo_half;
  wire [31:0] wr_word = {din_s, wr_lo};

  wire hit_rxd = (acc_byte & `PORT_ALIAS_MASK) == `RX_DATA_BASE;
  wire hit_txd = (acc_byte & `PORT_ALIAS_MASK) == `TX_DATA_BASE;
  target_type tgt;
  assign tgt = hit_rxd ? tgt_rx_data :
               hit_txd ? tgt_tx_data :
               (acc_word == `RX_STS_POP) ? tgt_rx_sts_pop :
               (acc_word == `RX_STS_PEEK) ? tgt_rx_sts_peek :
               (acc_word == `TX_STS_POP) ? tgt_tx_sts_pop :
               (acc_word == `TX_STS_PEEK) ? tgt_tx_sts_peek :
               (acc_word == `CTRL_REG) ? tgt_ctrl :
               (acc_word == `STAT_REG) ? tgt_stat : tgt_none;

  // fifo side signals
  logic rxd_valid;
  logic rxs_valid;
  logic txs_valid;
  logic txd_ready;
  logic txd_valid;
  logic [31:0] rxd_head;
  logic [31:0] rxs_head;
  logic [31:0] txs_head;
  logic [31:0] txd_head;
  logic [7:0] rxd_level;
  logic [7:0] rxs_level;
  logic [31:0] ctrl_value;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_value;
  logic [31:0] stat_rd;

  wire soft_rst = ctrl_value[`CTRL_SOFT_RST_BIT];
  wire tx_flush = ctrl_value[`CTRL_TX_FLUSH_BIT] || soft_rst;
  wire [7:0] rxd_limit = {3'b000, ctrl_value[`CTRL_RXD_LIM_LSB +: `CTRL_LIM_W]};
  wire [7:0] txd_limit = {3'b000, ctrl_value[`CTRL_TXD_LIM_LSB +: `CTRL_LIM_W]};
  wire [7:0] rxs_limit = {3'b000, ctrl_value[`CTRL_RXS_LIM_LSB +: `CTRL_LIM_W]};

  // pops only on completed pair reads
  wire rxd_pop = finish_rd && tgt == tgt_rx_data;
  wire rxs_pop = finish_rd && tgt == tgt_rx_sts_pop;
  wire txs_pop = finish_rd && tgt == tgt_tx_sts_pop;
  // push once the high half lands
  wire txd_push = finish_wr && tgt == tgt_tx_data;
  wire ctrl_wr = finish_wr && tgt == tgt_ctrl;
  wire stat_wr = finish_wr && tgt == tgt_stat;
  wire stat_rd_ev = fetch && tgt == tgt_stat;
  wire tx_stage_load = txd_valid && (!tx_data_valid || tx_data_ready);

  // peek ports share the head without popping
  logic [31:0] rd_word;
  logic head_empty;
  always_comb begin
    rd_word = 32'h0000_0000;
    head_empty = 1'b0;
    unique case (tgt)
      tgt_rx_data: begin
        rd_word = rxd_head;
        head_empty = !rxd_valid;
      end
      tgt_rx_sts_pop, tgt_rx_sts_peek: begin
        rd_word = rxs_head;
        head_empty = !rxs_valid;
      end
      tgt_tx_sts_pop, tgt_tx_sts_peek: begin
        rd_word = txs_head;
        head_empty = !txs_valid;
      end
      tgt_ctrl: rd_word = ctrl_rd;
      tgt_stat: rd_word = stat_rd;
      // transmit data and holes read zero
      tgt_tx_data, tgt_none: rd_word = 32'h0000_0000;
    endcase
  end
  wire [31:0] rd_safe = head_empty ? 32'h0000_0000 : rd_word;
  wire underrun = fetch && head_empty;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      rd_hi <= 16'h0000;
      wr_lo <= 16'h0000;
      host_data_out <= 16'h0000;
      host_data_oe <= 1'b0;
    end else begin
      rd_prev <= rd_act;
      wr_prev <= wr_act;
      host_data_oe <= rd_act;
      // low half fetches the word, high half replays it
      if (fetch) begin
        rd_hi <= rd_safe[31:16];
        host_data_out <= rd_safe[15:0];
      end else if (finish_rd) begin
        host_data_out <= rd_hi;
      end
      if (start_wr && lo_half) begin
        wr_lo <= din_s;
      end
    end
  end

  // output stage keeps the transmit data port on flops
  always_ff @(posedge core_clk) begin
    if (rst || tx_flush) begin
      tx_data_valid <= 1'b0;
      tx_stage <= 32'h0000_0000;
    end else if (tx_stage_load) begin
      tx_data_valid <= 1'b1;
      tx_stage <= txd_head;
    end else if (tx_data_ready) begin
      tx_data_valid <= 1'b0;
    end
  end
  assign tx_data = tx_stage;

  stream_fifo #(.WIDTH(32), .DEPTH(DATA_DEPTH)) u_rx_data (
    .core_clk(core_clk),
    .rst(rst),
    .flush(soft_rst),
    .limit(rxd_limit),
    .in_valid(rx_data_valid),
    .in_data(rx_data),
    .in_ready(rx_data_ready),
    .out_valid(rxd_valid),
    .out_data(rxd_head),
    .out_ready(rxd_pop),
    .level(rxd_level)
  );

  stream_fifo #(.WIDTH(32), .DEPTH(STS_DEPTH)) u_rx_sts (
    .core_clk(core_clk),
    .rst(rst),
    .flush(soft_rst),
    .limit(rxs_limit),
    .in_valid(rx_sts_valid),
    .in_data(rx_sts),
    .in_ready(rx_sts_ready),
    .out_valid(rxs_valid),
    .out_data(rxs_head),
    .out_ready(rxs_pop),
    .level(rxs_level)
  );

  stream_fifo #(.WIDTH(32), .DEPTH(STS_DEPTH)) u_tx_sts (
    .core_clk(core_clk),
    .rst(rst),
    .flush(soft_rst),
    .limit(`TXS_LIMIT),
    .in_valid(tx_sts_valid),
    .in_data(tx_sts),
    .in_ready(tx_sts_ready),
    .out_valid(txs_valid),
    .out_data(txs_head),
    .out_ready(txs_pop),
    .level()
  );

  // a write into a full transmit queue is dropped
  stream_fifo #(.WIDTH(32), .DEPTH(DATA_DEPTH)) u_tx_data (
    .core_clk(core_clk),
    .rst(rst),
    .flush(tx_flush),
    .limit(txd_limit),
    .in_valid(txd_push),
    .in_data(wr_word),
    .in_ready(txd_ready),
    .out_valid(txd_valid),
    .out_data(txd_head),
    .out_ready(tx_stage_load),
    .level()
  );

  attr_reg #(
    .RST_VAL(`CTRL_RST_VAL),
    .RO_MASK(`CTRL_RO_MASK),
    .WO_MASK(`CTRL_WO_MASK),
    .AUTO_CLR_MASK(`CTRL_AUTO_CLR_MASK),
    .KEEP_MASK(`CTRL_KEEP_MASK)
  ) u_ctrl (
    .core_clk(core_clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .wr_en(ctrl_wr),
    .wr_data(wr_word),
    .rd_en(1'b0),
    .hw_set(32'h0000_0000),
    .hw_low(32'h0000_0000),
    .hw_val(32'h0000_0000),
    .value(ctrl_value),
    .rd_value(ctrl_rd)
  );

  wire [31:0] stat_set = {27'h0000000, 1'b0, tx_sts_valid && !tx_sts_ready, underrun,
                          rx_sts_valid && !rx_sts_ready, rx_data_valid && !rx_data_ready};
  wire [31:0] stat_low = {27'h0000000, !txd_ready, 4'h0};
  attr_reg #(
    .RST_VAL(`STAT_RST_VAL),
    .RO_MASK(`STAT_RO_MASK),
    .W1C_MASK(`STAT_W1C_MASK),
    .RC_MASK(`STAT_RC_MASK),
    .LATCH_HI_MASK(`STAT_LATCH_HI_MASK),
    .LATCH_LO_MASK(`STAT_LATCH_LO_MASK)
  ) u_stat (
    .core_clk(core_clk),
    .rst(rst),
    .soft_rst(soft_rst),
    .wr_en(stat_wr),
    .wr_data(wr_word),
    .rd_en(stat_rd_ev),
    .hw_set(stat_set),
    .hw_low(stat_low),
    .hw_val({rxs_level, rxd_level, 16'h0000}),
    .value(stat_value),
    .rd_value(stat_rd)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_ctrl_fetch;
    fetch && tgt == tgt_ctrl;
  endsequence
  sequence s_soft_pulse;
    soft_rst ##1 !soft_rst;
  endsequence

  a_wo_reads_zero: assert property (s_ctrl_fetch |-> (rd_safe & `CTRL_WO_MASK) == 32'h0)
    else $error("write-only bit read nonzero");
  a_w1c_clears: assert property ((stat_wr && wr_word[0] && !stat_set[0] && !soft_rst)
    |=> !stat_value[0])
    else $error("write-one-clear bit stayed set");
  a_rc_read_clear: assert property ((stat_rd_ev && !underrun && !soft_rst)
    |=> !stat_value[2])
    else $error("read-clear bit survived read");
  a_latch_hi_hold: assert property ((stat_value[3] && !stat_rd_ev && !soft_rst)
    |=> stat_value[3])
    else $error("latched flag lost before read");
  a_keep_soft_rst: assert property (s_soft_pulse |->
    ctrl_value[27:20] == $past(ctrl_value[27:20], 1))
    else $error("kept field changed on soft reset");
  a_soft_defaults: assert property (soft_rst |=> (ctrl_value & ~`CTRL_KEEP_MASK)
    == (`CTRL_RST_VAL & ~`CTRL_KEEP_MASK))
    else $error("soft reset missed defaults");
  a_pop_removes: assert property ((rxd_pop && rxd_valid && !(rx_data_valid && rx_data_ready)
    && !soft_rst) |=> rxd_level == $past(rxd_level) - 8'h01)
    else $error("receive data read did not pop");
  a_peek_keeps: assert property ((start_rd && tgt == tgt_rx_sts_peek && !soft_rst)
    |=> rxs_level >= $past(rxs_level))
    else $error("peek removed an entry");
  a_self_clear_bit: assert property (ctrl_value[`CTRL_TX_FLUSH_BIT] && !ctrl_wr
    |=> !ctrl_value[`CTRL_TX_FLUSH_BIT])
    else $error("self-clearing bit stuck");
  a_pair_push: assert property ((start_wr && lo_half) |-> !txd_push)
    else $error("push on low half write");
endmodule

// [common/host_fifo_regs.svh]
`ifndef HOST_FIFO_REGS_SVH
`define HOST_FIFO_REGS_SVH

// byte offsets on the 16-bit host bus, word aligned
`define RX_DATA_BASE 8'h00
`define TX_DATA_BASE 8'h40
`define PORT_ALIAS_MASK 8'hC0
`define RX_STS_POP 8'h80
`define RX_STS_PEEK 8'h84
`define TX_STS_POP 8'h88
`define TX_STS_PEEK 8'h8C
`define CTRL_REG 8'h90
`define STAT_REG 8'h94

// control register fields
`define CTRL_SOFT_RST_BIT 0
`define CTRL_TX_FLUSH_BIT 1
`define CTRL_RXD_LIM_LSB 4
`define CTRL_TXD_LIM_LSB 9
`define CTRL_RXS_LIM_LSB 14
`define CTRL_LIM_W 5
`define CTRL_KEEP_LSB 20
`define CTRL_KEEP_W 8
`define CTRL_RST_VAL 32'h0004_2100
`define CTRL_RO_MASK 32'hF008_000C
`define CTRL_WO_MASK 32'h0000_0003
`define CTRL_AUTO_CLR_MASK 32'h0000_0003
`define CTRL_KEEP_MASK 32'h0FF0_0000

// status register fields
`define STAT_RXD_OVR_BIT 0
`define STAT_RXS_OVR_BIT 1
`define STAT_UNDERRUN_BIT 2
`define STAT_TXS_OVR_BIT 3
`define STAT_TXD_ROOM_BIT 4
`define STAT_RST_VAL 32'h0000_0010
`define STAT_RO_MASK 32'hFFFF_FFE0
`define STAT_W1C_MASK 32'h0000_0003
`define STAT_RC_MASK 32'h0000_0004
`define STAT_LATCH_HI_MASK 32'h0000_0008
`define STAT_LATCH_LO_MASK 32'h0000_0010

`define TXS_LIMIT 8'h10

`endif

// [common/host_fifo_pkg.sv]
package host_fifo_pkg;
  typedef enum logic [3:0] {
    tgt_none,
    tgt_rx_data,
    tgt_tx_data,
    tgt_rx_sts_pop,
    tgt_rx_sts_peek,
    tgt_tx_sts_pop,
    tgt_tx_sts_peek,
    tgt_ctrl,
    tgt_stat
  } target_type;
endpackage

// [rtl/stream_fifo.sv]
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic flush,
  input wire logic [7:0] limit,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic [7:0] level
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [7:0] DEPTH_W = 8'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [7:0] next_level;
  logic [7:0] eff_limit;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign next_level = level + {7'h00, push} - {7'h00, pop};
  // a limit above the storage is clamped, so full stays honest
  assign eff_limit = (limit > DEPTH_W) ? DEPTH_W : limit;
  assign out_data = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= 8'h00;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      level <= next_level;
      in_ready <= next_level < eff_limit;
      out_valid <= next_level != 8'h00;
    end
  end

  a_fifo_bound: assert property (@(posedge core_clk) disable iff (rst)
    level <= DEPTH_W) else $error("fifo level above depth");
  a_fifo_count: assert property (@(posedge core_clk) disable iff (rst)
    (!flush && push && !pop) |=> level == $past(level) + 8'h01)
    else $error("fifo level did not follow push");
endmodule

// [rtl/attr_reg.sv]
`timescale 1ns/1ps
module attr_reg #(
  parameter logic [31:0] RST_VAL = 32'h0000_0000,
  parameter logic [31:0] RO_MASK = 32'h0000_0000,
  parameter logic [31:0] WO_MASK = 32'h0000_0000,
  parameter logic [31:0] W1C_MASK = 32'h0000_0000,
  parameter logic [31:0] RC_MASK = 32'h0000_0000,
  parameter logic [31:0] LATCH_HI_MASK = 32'h0000_0000,
  parameter logic [31:0] LATCH_LO_MASK = 32'h0000_0000,
  parameter logic [31:0] AUTO_CLR_MASK = 32'h0000_0000,
  parameter logic [31:0] KEEP_MASK = 32'h0000_0000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic soft_rst,
  input wire logic wr_en,
  input wire logic [31:0] wr_data,
  input wire logic rd_en,
  input wire logic [31:0] hw_set,
  input wire logic [31:0] hw_low,
  input wire logic [31:0] hw_val,
  output logic [31:0] value,
  output logic [31:0] rd_value
);
  assign rd_value = value & ~WO_MASK;

  for (genvar i = 0; i < 32; i++) begin : g_bit
    always_ff @(posedge core_clk) begin
      if (rst) begin
        value[i] <= RST_VAL[i];
      // kept bits ride through soft reset
      end else if (soft_rst && !KEEP_MASK[i]) begin
        value[i] <= RST_VAL[i];
      end else if (RO_MASK[i]) begin
        value[i] <= hw_val[i];
      end else if (W1C_MASK[i]) begin
        if (hw_set[i]) begin
          value[i] <= 1'b1;
        end else if (wr_en && wr_data[i]) begin
          value[i] <= 1'b0;
        end
      end else if (RC_MASK[i] || LATCH_HI_MASK[i]) begin
        if (hw_set[i]) begin
          value[i] <= 1'b1;
        end else if (rd_en) begin
          value[i] <= 1'b0;
        end
      end else if (LATCH_LO_MASK[i]) begin
        if (hw_low[i]) begin
          value[i] <= 1'b0;
        end else if (rd_en) begin
          value[i] <= 1'b1;
        end
      end else if (AUTO_CLR_MASK[i]) begin
        value[i] <= wr_en && wr_data[i];
      end else if (wr_en) begin
        value[i] <= wr_data[i];
      end
    end
  end
endmodule

// [tb/host_cpu_model.sv]
`timescale 1ns/1ps
module host_cpu_model (
  input wire logic core_clk,
  input wire logic host_data_oe,
  output logic host_cs_n,
  output logic host_rd_n,
  output logic host_wr_n,
  output logic [7:1] host_addr,
  output logic [15:0] host_data_in,
  output int miss_count
);
  initial begin
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    host_addr = 7'h00;
    host_data_in = 16'hFFFF;
    miss_count = 0;
  end

  task automatic access(input logic [7:0] a, input logic wr, input logic [15:0] d);
    int n;
    @(posedge core_clk);
    #1;
    host_cs_n = 1'b0;
    host_addr = a[7:1];
    host_rd_n = wr;
    host_wr_n = !wr;
    if (wr) host_data_in = d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (n < 5 && (wr || host_data_oe !== 1'b1));
    if (!wr && host_data_oe !== 1'b1) miss_count++;
    #1;
    host_cs_n = 1'b1;
    host_rd_n = 1'b1;
    host_wr_n = 1'b1;
    // released bus shows the inverse, not a stale copy
    host_data_in = ~host_data_in;
    // strobes stay apart at least three clocks
    repeat (4) @(posedge core_clk);
  endtask

  task automatic rd32(input logic [7:0] a);
    access(a, 1'b0, 16'h0000);
    access(a | 8'h02, 1'b0, 16'h0000);
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    access(a, 1'b1, d[15:0]);
    access(a | 8'h02, 1'b1, d[31:16]);
  endtask
endmodule

// [tb/test_host_fifo_port_access.sv]
`timescale 1ns/1ps
`include "host_fifo_regs.svh"
module test_host_fifo_port_access;
  logic core_clk, rst, host_cs_n, host_rd_n, host_wr_n, host_data_oe, oe_q;
  logic [7:1] host_addr;
  logic [15:0] host_data_in, host_data_out;
  logic rx_data_valid, rx_data_ready, rx_sts_valid, rx_sts_ready;
  logic tx_sts_valid, tx_sts_ready, tx_data_valid, tx_data_ready;
  logic [31:0] rx_data, rx_sts, tx_sts, tx_data;
  int err_count, n_checks, cycles, miss_count;
  logic [15:0] exp_q[$];
  string name_q[$];
  logic [31:0] txq[$];

  host_fifo_port_access i_host_fifo_port_access (.core_clk(core_clk), .rst(rst),
    .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
    .host_addr(host_addr), .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .rx_data_valid(rx_data_valid), .rx_data(rx_data),
    .rx_data_ready(rx_data_ready), .rx_sts_valid(rx_sts_valid), .rx_sts(rx_sts),
    .rx_sts_ready(rx_sts_ready), .tx_sts_valid(tx_sts_valid), .tx_sts(tx_sts),
    .tx_sts_ready(tx_sts_ready), .tx_data_valid(tx_data_valid), .tx_data(tx_data),
    .tx_data_ready(tx_data_ready));

  host_cpu_model i_host_cpu_model (.core_clk(core_clk), .host_data_oe(host_data_oe),
    .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
    .host_addr(host_addr), .host_data_in(host_data_in), .miss_count(miss_count));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    err_count += miss_count;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic expect_rd(input string what, input logic [7:0] a, input logic [31:0] v);
    name_q.push_back({what, "_lo"});
    exp_q.push_back(v[15:0]);
    name_q.push_back({what, "_hi"});
    exp_q.push_back(v[31:16]);
    i_host_cpu_model.rd32(a);
  endtask

  task automatic push(input int k, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    #1;
    rx_data_valid = (k == 0);
    rx_sts_valid = (k == 1);
    tx_sts_valid = (k == 2);
    rx_data = d;
    rx_sts = d;
    tx_sts = d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (n < 20 && (k == 0 ? rx_data_ready : k == 1 ? rx_sts_ready : tx_sts_ready) !== 1'b1);
    if (n >= 20) check("stream_accept", 32'h1, 32'h0);
    #1;
    {rx_data_valid, rx_sts_valid, tx_sts_valid} = 3'b000;
    rx_data = ~d;
    rx_sts = ~d;
    tx_sts = ~d;
  endtask

  // one result checker for both halves of every read and for the tx stream
  always @(posedge core_clk) begin
    oe_q <= host_data_oe;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
    if (host_data_oe === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() == 0) check("unexpected_read", 32'h0, 32'h1);
      else check(name_q.pop_front(), {16'h0, exp_q.pop_front()}, {16'h0, host_data_out});
    end
    if (tx_data_valid === 1'b1 && tx_data_ready === 1'b1) begin
      if (txq.size() == 0) check("unexpected_tx", 32'h0, 32'h1);
      else check("tx_data", txq.pop_front(), tx_data);
    end
  end

  // far side stalls at random
  always @(posedge core_clk) begin
    #1;
    tx_data_ready = ($urandom % 4) != 0;
  end

  initial begin
    logic [31:0] w[6];
    logic [7:0] peek_a, pop_a;
    int i, k, n;
    {rx_data_valid, rx_sts_valid, tx_sts_valid} = 3'b000;
    rx_data = 32'h0;
    rx_sts = 32'h0;
    tx_sts = 32'h0;
    rst = 1'b1;
    oe_q = 1'b0;
    err_count = 0;
    n_checks = 0;
    cycles = 0;
    void'($urandom(33138));
    repeat (12) @(posedge core_clk);
    #1;
    rst = 1'b0;
    repeat (3) @(posedge core_clk);
    expect_rd("ctrl_reset", `CTRL_REG, `CTRL_RST_VAL);
    expect_rd("stat_reset", `STAT_REG, `STAT_RST_VAL);
    i_host_cpu_model.wr32(`STAT_REG, 32'hFFFF_0000);
    expect_rd("stat_ro", `STAT_REG, `STAT_RST_VAL);
    // scratch A5, rx data limit 5, tx data limit 0, flush bit written high
    i_host_cpu_model.wr32(`CTRL_REG, 32'h0A54_0052);
    expect_rd("ctrl_wo", `CTRL_REG, 32'h0A54_0050);
    for (i = 0; i < 5; i++) push(0, $urandom());
    repeat (2) @(posedge core_clk);
    check("rx_ready_at_limit", 32'h0, {31'h0, rx_data_ready});
    for (i = 0; i < 16; i++) push(2, $urandom());
    // both queues full: one refused beat each raises its overrun flag
    @(posedge core_clk);
    #1;
    {rx_data_valid, tx_sts_valid} = 2'b11;
    @(posedge core_clk);
    #1;
    {rx_data_valid, tx_sts_valid} = 2'b00;
    expect_rd("stat_level", `STAT_REG, 32'h0005_0009);
    i_host_cpu_model.wr32(`STAT_REG, 32'h0000_0001);
    expect_rd("stat_w1c", `STAT_REG, 32'h0005_0000);
    // room returns, but the low latch waits for a read
    i_host_cpu_model.wr32(`CTRL_REG, 32'h0A54_2050);
    expect_rd("stat_ll_hold", `STAT_REG, 32'h0005_0000);
    expect_rd("stat_ll_rearm", `STAT_REG, 32'h0005_0010);
    i_host_cpu_model.wr32(`CTRL_REG, 32'h0A54_2051);
    expect_rd("ctrl_soft", `CTRL_REG, 32'h0A54_2100);
    expect_rd("stat_soft", `STAT_REG, `STAT_RST_VAL);
    for (i = 0; i < 4; i++) begin
      w[i] = $urandom();
      push(0, w[i]);
    end
    i_host_cpu_model.wr32(`RX_DATA_BASE, 32'hDEAD_BEEF);
    for (i = 0; i < 4; i++) expect_rd("rx_data", 8'h04 * (i * 5), w[i]);
    expect_rd("rx_empty", 8'h20, 32'h0);
    expect_rd("stat_rc_set", `STAT_REG, 32'h0000_0014);
    expect_rd("stat_rc_clr", `STAT_REG, `STAT_RST_VAL);
    for (k = 1; k < 3; k++) begin
      peek_a = (k == 1) ? `RX_STS_PEEK : `TX_STS_PEEK;
      pop_a = (k == 1) ? `RX_STS_POP : `TX_STS_POP;
      w[0] = $urandom();
      w[1] = $urandom();
      push(k, w[0]);
      push(k, w[1]);
      expect_rd("sts_peek", peek_a, w[0]);
      expect_rd("sts_peek_again", peek_a, w[0]);
      expect_rd("sts_pop", pop_a, w[0]);
      expect_rd("sts_peek_next", peek_a, w[1]);
      expect_rd("sts_pop_next", pop_a, w[1]);
    end
    for (i = 0; i < 6; i++) begin
      w[i] = $urandom();
      txq.push_back(w[i]);
      i_host_cpu_model.wr32(`TX_DATA_BASE + 8'h04 * ((i * 3) % 16), w[i]);
    end
    n = 0;
    while (txq.size() != 0 && n < 200) begin
      @(posedge core_clk);
      n++;
    end
    check("tx_drained", 32'h0, txq.size());
    wrap_up();
  end
endmodule
